/* ssl_peer.sv */
// Far-side serial peer on the three-wire link
`timescale 1ns/1ns
module ssl_peer (
  input wire logic edge_select_in,
  input wire logic clk_line_in,
  input wire logic dout_line_in,
  output logic clk_drive_out,
  output logic din_out,
  output logic [7:0] rx_out
);
  logic [7:0] sh = 8'h00;
  int nb = 0;
  initial begin
    clk_drive_out = 1'b1;
    din_out = 1'b1;
    rx_out = 8'h00;
  end
  task automatic load(input logic [7:0] d);
    sh = d;
    nb = 0;
  endtask
  always @(clk_line_in) begin
    // Only the eight bits of a frame; the clock's return to idle is no bit
    if (clk_line_in ^ edge_select_in) begin
      if (nb < 8) begin
        rx_out = {rx_out[6:0], dout_line_in};
        nb++;
      end
    end else begin
      din_out = sh[7];
      sh = sh << 1;
    end
  end
  // eight 80 ns clocks, last bit kept a full bit
  task automatic frame;
    repeat (8) begin
      #40 clk_drive_out = 1'b0;
      #40 clk_drive_out = 1'b1;
    end
    #80 din_out = ~din_out;
  endtask
endmodule

/* ssl_pkg.sv */
// Package: constants and types of the serial last-bit and pin block
package ssl_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int SSL_CLK_HZ = 100000000;
  // Internal transfer clock divider count after reset; the half period is one system cycle more
  localparam logic [7:0] SSL_DIV_RESET = 8'h04;
  localparam logic [3:0] SSL_BITS_RESET = 4'h8;
  localparam logic SSL_LINE_IDLE = 1'b1;

  // ---------------------------------------------------------------
  // Transfer state machine
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    SSL_IDLE = 4'b0001,
    SSL_SHIFT = 4'b0010,
    SSL_HOLD = 4'b0100,
    SSL_DONE = 4'b1000
  } ssl_state_e;
endpackage

/* ssl_sva.sv */
// Checker for the serial last-bit and pin block
`timescale 1ns/1ns
module ssl_chk (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic start_in,
  input wire logic clock_master_select_in,
  input wire logic data_out_function_select_in,
  input wire logic data_in_function_select_in,
  input wire logic port_data_out_in,
  input wire logic serial_clock_pin_oe_n_out,
  input wire logic serial_data_out_pin_out,
  input wire logic busy_out,
  input wire logic transfer_complete_irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  wire logic fsel_on = data_out_function_select_in | data_in_function_select_in;
  sequence s_take;
    start_in && !busy_out && fsel_on && !transfer_complete_irq_out;
  endsequence
  sequence s_done;
    transfer_complete_irq_out;
  endsequence
  a_start_sets_busy: assert property (s_take |=> busy_out)
    else $error("busy not raised");
  a_done_line_high: assert property (s_done and data_out_function_select_in |=>
    serial_data_out_pin_out) else $error("line not high");
  a_done_busy_low: assert property (s_done |-> !busy_out)
    else $error("busy at end");
  a_irq_one_cycle: assert property (s_done |=> !transfer_complete_irq_out)
    else $error("irq too long");
  a_forced_idle: assert property (!fsel_on |=> !busy_out && !transfer_complete_irq_out)
    else $error("forced reset ignored");
  a_port_follow: assert property ($past(nrst_in) && !data_out_function_select_in &&
    $past(!data_out_function_select_in) |-> serial_data_out_pin_out == $past(port_data_out_in))
    else $error("port level lost");
  a_slave_clk_off: assert property ($past(nrst_in) && !clock_master_select_in &&
    $past(!clock_master_select_in) |-> serial_clock_pin_oe_n_out) else $error("slave drives clock");
  a_busy_fell_why: assert property ($fell(busy_out) |-> s_done or !$past(fsel_on))
    else $error("busy dropped early");
endmodule
bind ssl_top ssl_chk chk_u (.clk_in, .nrst_in, .start_in, .clock_master_select_in,
  .data_out_function_select_in, .data_in_function_select_in, .port_data_out_in,
  .serial_clock_pin_oe_n_out, .serial_data_out_pin_out, .busy_out, .transfer_complete_irq_out);

/* ssl_sync.sv */
// Two-flop synchronisers for the three serial pins
`timescale 1ns/1ns
module ssl_sync (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic clk_pin_in,
  input wire logic din_pin_in,
  input wire logic dout_pin_in,
  ssl_sync_if.src sync
);
  logic [2:0] meta;
  logic [2:0] stable;

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      meta <= 3'h7;
      stable <= 3'h7;
    end else begin
      meta <= {clk_pin_in, din_pin_in, dout_pin_in};
      stable <= meta;
    end
  end

  assign sync.clk_lvl = stable[2];
  assign sync.din_lvl = stable[1];
  assign sync.dout_lvl = stable[0];
endmodule

/* ssl_sync_if.sv */
// Interface: synchronised pin levels passed to the main module
`timescale 1ns/1ns
interface ssl_sync_if;
  logic clk_lvl;
  logic din_lvl;
  logic dout_lvl;
  modport src (output clk_lvl, output din_lvl, output dout_lvl);
  modport dst (input clk_lvl, input din_lvl, input dout_lvl);
endinterface

/* ssl_top.sv */
// Serial shift core: last-bit hold, edge select and three-wire pin setup
// What this block does
// - Drive output high after last-bit hold.
// - Hold last bit one/half-plus bit period.
// - Internal clock sets slave last-bit hold.
// - Sample on edge opposite to shift edge.
// - Transmit-only: data out, input forced one.
// - Receive-only: out pin port, in serial.
// - Full duplex: both data pins serve serial.
// - Edge select picks shift/sample edges.
// - Master select; internal clock makes completion flag.
// - Input select: dedicated pin or out pin.
`timescale 1ns/1ns
module ssl_top #(
  parameter int BITS_W = 4
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic start_in,
  input wire logic [7:0] tx_data_in,
  input wire logic [BITS_W-1:0] bit_count_in,
  input wire logic [7:0] clock_divider_in,
  input wire logic edge_select_in,
  input wire logic clock_master_select_in,
  input wire logic input_pin_select_in,
  input wire logic data_out_function_select_in,
  input wire logic data_in_function_select_in,
  input wire logic clock_pin_function_select_in,
  input wire logic data_out_drive_type_in,
  input wire logic clock_drive_type_in,
  input wire logic port_data_out_in,
  input wire logic serial_clock_pin_in,
  input wire logic serial_data_in_pin_in,
  input wire logic serial_data_out_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe_n_out,
  output logic serial_data_out_pin_out,
  output logic serial_data_out_pin_oe_n_out,
  output logic [7:0] rx_data_out,
  output logic busy_out,
  output logic transfer_complete_irq_out
);
  import ssl_pkg::*;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  ssl_sync_if sync ();
  ssl_sync u_sync (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .clk_pin_in(serial_clock_pin_in),
    .din_pin_in(serial_data_in_pin_in),
    .dout_pin_in(serial_data_out_pin_in),
    .sync(sync)
  );

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  ssl_state_e state;
  logic [7:0] div_cnt;
  logic int_clk;
  logic int_clk_d;
  logic ext_clk_d;
  logic [BITS_W-1:0] bits_left;
  logic [7:0] shreg;
  logic tx_bit;
  logic half_seen;

  // ---------------------------------------------------------------
  // Decoding
  // ---------------------------------------------------------------
  wire div_tick = (div_cnt == 8'h00);
  // Internal clock always runs while busy, it times the completion flag
  // master select clock
  wire sel_clk = clock_master_select_in ? int_clk : sync.clk_lvl;
  wire sel_clk_d = clock_master_select_in ? int_clk_d : ext_clk_d;
  wire rise = sel_clk & ~sel_clk_d;
  wire fall = ~sel_clk & sel_clk_d;
  wire shift_edge = edge_select_in ? rise : fall;
  wire sample_edge = edge_select_in ? fall : rise;
  wire raw_rx = input_pin_select_in ? sync.dout_lvl : sync.din_lvl;
  wire rx_bit = data_in_function_select_in ? raw_rx : 1'b1;
  wire int_fall = ~int_clk & int_clk_d;
  wire last_bit = (bits_left == '0);
  wire forced_reset = ~data_out_function_select_in & ~data_in_function_select_in;

  // ---------------------------------------------------------------
  // Internal transfer clock divider
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      div_cnt <= SSL_DIV_RESET;
      int_clk <= 1'b1;
      int_clk_d <= 1'b1;
      ext_clk_d <= 1'b1;
    end else begin
      int_clk_d <= int_clk;
      ext_clk_d <= sync.clk_lvl;
      if (state == SSL_IDLE) begin
        div_cnt <= clock_divider_in;
        int_clk <= 1'b1;
      end else if (div_tick) begin
        div_cnt <= clock_divider_in;
        int_clk <= ~int_clk;
      end else begin
        div_cnt <= div_cnt - 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // Transfer sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      state <= SSL_IDLE;
      bits_left <= '0;
      shreg <= 8'h00;
      tx_bit <= SSL_LINE_IDLE;
      half_seen <= 1'b0;
      rx_data_out <= 8'h00;
      busy_out <= 1'b0;
      transfer_complete_irq_out <= 1'b0;
    end else if (forced_reset) begin
      state <= SSL_IDLE;
      busy_out <= 1'b0;
      tx_bit <= SSL_LINE_IDLE;
      transfer_complete_irq_out <= 1'b0;
    end else begin
      transfer_complete_irq_out <= 1'b0;
      unique case (state)
        SSL_IDLE: begin
          if (start_in) begin
            shreg <= tx_data_in;
            bits_left <= bit_count_in - 1'b1;
            busy_out <= 1'b1;
            state <= SSL_SHIFT;
          end
        end
        SSL_SHIFT: begin
          if (shift_edge) begin
            tx_bit <= shreg[7];
          end
          if (sample_edge) begin
            shreg <= {shreg[6:0], rx_bit};
            if (last_bit) begin
              half_seen <= 1'b0;
              state <= SSL_HOLD;
            end else begin
              bits_left <= bits_left - 1'b1;
            end
          end
        end
        SSL_HOLD: begin
          // slave hold uses internal clock
          // Master: until next shift edge; slave: next internal falling edge
          if (clock_master_select_in ? shift_edge : int_fall) begin
            state <= SSL_DONE;
          end
        end
        SSL_DONE: begin
          tx_bit <= SSL_LINE_IDLE;
          rx_data_out <= shreg;
          busy_out <= 1'b0;
          transfer_complete_irq_out <= 1'b1;
          state <= SSL_IDLE;
        end
        default: state <= SSL_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Pin drivers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      serial_clock_pin_out <= 1'b1;
      serial_clock_pin_oe_n_out <= 1'b1;
      serial_data_out_pin_out <= 1'b1;
      serial_data_out_pin_oe_n_out <= 1'b1;
    end else begin
      serial_clock_pin_out <= int_clk;
      serial_clock_pin_oe_n_out <= ~(clock_pin_function_select_in & clock_master_select_in)
                                   | (clock_drive_type_in & int_clk);
      if (data_out_function_select_in && !input_pin_select_in) begin
        serial_data_out_pin_out <= tx_bit;
        serial_data_out_pin_oe_n_out <= data_out_drive_type_in & tx_bit;
      end else begin
        serial_data_out_pin_out <= port_data_out_in;
        serial_data_out_pin_oe_n_out <= input_pin_select_in;
      end
    end
  end
endmodule

/* ssl_top_test.sv */
// Bench for the serial last-bit and pin block
`timescale 1ns/1ns
module ssl_top_test;
  import ssl_pkg::*;
  logic clk_in = 0, nrst_in = 0, start_in = 0, ms = 1, dofs = 1, difs = 1, pdo = 0, es = 0;
  logic [7:0] tx = 0, div = 8'h04, rx;
  logic ck_oe_n, ck_o, do_oe_n, do_o, busy, irq, pck, pdin;
  int failures = 0, total_checks = 0, cyc = 0, n = 0;
  wire logic ck_line = ck_oe_n ? pck : ck_o;
  wire logic do_line = do_oe_n ? 1'b1 : do_o;
  always #5 clk_in = ~clk_in;
  ssl_top dut_u (.clk_in, .nrst_in, .start_in, .tx_data_in(tx), .bit_count_in(4'h8),
    .clock_divider_in(div), .edge_select_in(es), .clock_master_select_in(ms),
    .input_pin_select_in(1'b0), .data_out_function_select_in(dofs),
    .data_in_function_select_in(difs), .clock_pin_function_select_in(1'b1),
    .data_out_drive_type_in(1'b0), .clock_drive_type_in(1'b0), .port_data_out_in(pdo),
    .serial_clock_pin_in(ck_line), .serial_data_in_pin_in(pdin), .serial_data_out_pin_in(do_line),
    .serial_clock_pin_out(ck_o), .serial_clock_pin_oe_n_out(ck_oe_n),
    .serial_data_out_pin_out(do_o), .serial_data_out_pin_oe_n_out(do_oe_n),
    .rx_data_out(rx), .busy_out(busy), .transfer_complete_irq_out(irq));
  ssl_peer peer_u (.edge_select_in(es), .clk_line_in(ck_line), .dout_line_in(do_line),
    .clk_drive_out(pck), .din_out(pdin), .rx_out());
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish;
    if (failures == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One transfer: master m, out pin serial o, input serial i
  task automatic run(input logic m, input logic o, input logic i, input logic [7:0] d,
    input logic [7:0] p);
    @(posedge clk_in);
    ms <= m;
    dofs <= o;
    difs <= i;
    tx <= d;
    div <= m ? 8'h04 : 8'h03;
    peer_u.load(p);
    @(posedge clk_in);
    start_in <= 1'b1;
    @(posedge clk_in);
    start_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    if (!m) fork peer_u.frame(); join_none
    for (int k = 0; k < 3000 && irq !== 1'b1; k++) @(negedge clk_in);
    chk("irq", 8'h01, {7'h00, irq});
    chk("rx", i ? p : 8'hff, rx);
    @(negedge clk_in);
    chk("line_end", {7'h00, o}, {7'h00, do_o});
    if (o) chk("peer_rx", d, peer_u.rx_out);
    repeat (30) @(posedge clk_in);
  endtask
  task automatic sc_abort;
    @(posedge clk_in);
    ms <= 1'b1;
    start_in <= 1'b1;
    @(posedge clk_in);
    start_in <= 1'b0;
    repeat (20) @(posedge clk_in);
    dofs <= 1'b0;
    difs <= 1'b0;
    repeat (3) @(negedge clk_in);
    chk("busy_abort", 8'h00, {7'h00, busy});
    repeat (200) @(negedge clk_in) if (irq !== 1'b0) n++;
    chk("irq_abort", 8'h00, n[7:0]);
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (10) @(posedge clk_in);
    nrst_in <= 1'b1;
    run(1'b1, 1'b1, 1'b1, 8'ha5, 8'h3c);
    run(1'b0, 1'b1, 1'b1, 8'hc3, 8'h5a);
    run(1'b1, 1'b1, 1'b0, 8'h96, 8'h5a);
    run(1'b1, 1'b0, 1'b1, 8'h00, 8'h69);
    sc_abort();
    run(1'b1, 1'b1, 1'b1, 8'hff, 8'h01);
    tally_and_finish();
  end
endmodule
